// ==== sxe_cfg.svh ====
// Offsets, field positions, direction-load selects and reset values of the exec block
`ifndef SXE_CFG_SVH
`define SXE_CFG_SVH

// Register byte offsets on the bus
`define SXE_ACC_OFS        8'h00
`define SXE_STATUS_OFS     8'h04
`define SXE_DIR_A_OFS      8'h08
`define SXE_DIR_B_OFS      8'h0c
`define SXE_DIR_C_OFS      8'h10
`define SXE_WDT_OFS        8'h14
`define SXE_CTRL_OFS       8'h18

// Status register bit positions
`define SXE_ST_CARRY       0
`define SXE_ST_DCARRY      1
`define SXE_ST_ZERO        2
`define SXE_ST_PD_N        3
`define SXE_ST_TO_N        4

// Control register bit positions
`define SXE_CT_WDT_EN      0
`define SXE_CT_WAKE        1
`define SXE_CT_SLEEPING    2

// Direction-load operand selects
`define SXE_DIR_SEL_A      7'h05
`define SXE_DIR_SEL_B      7'h06
`define SXE_DIR_SEL_C      7'h07

// Reset value of the direction registers; zero for the default result
`define SXE_DIR_RESET      8'hff
`define SXE_ZERO8          8'h00

`endif

// ==== sxe_pkg.sv ====
// Types shared by the subtract, exclusive-OR and swap execution block
package sxe_pkg;

    // Instruction codes issued by the decoder
    typedef enum logic [3:0] {
        SXE_OP_NONE      = 4'h0,
        SXE_OP_LIT_SUB   = 4'h1,
        SXE_OP_FILE_SUB  = 4'h2,
        SXE_OP_FILE_SUBB = 4'h3,
        SXE_OP_NIB_EX    = 4'h4,
        SXE_OP_XOR_LIT   = 4'h5,
        SXE_OP_XOR_FILE  = 4'h6,
        SXE_OP_DIR_LOAD  = 4'h7,
        SXE_OP_SLEEP     = 4'h8
    } sxe_op_type;

    // Run or sleep
    typedef enum logic {
        SXE_RUN   = 1'b0,
        SXE_SLEEP = 1'b1
    } sxe_mode_type;

    // One instruction from the decoder
    typedef struct packed {
        logic       valid;
        sxe_op_type op;
        logic [7:0] operand;   // Literal or file register contents
        logic [6:0] addr;      // File address or direction select
        logic       dest;      // 0 to accumulator, 1 to file
    } sxe_req_type;

    // Write back into the file register
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] data;
    } sxe_fwr_type;

    // Whole state of the block
    typedef struct packed {
        sxe_mode_type mode;
        logic [7:0]   acc;
        logic         carry;
        logic         dcarry;
        logic         zero;
        logic         pd_n;
        logic         to_n;
        logic [7:0]   dir_a;
        logic [7:0]   dir_b;
        logic [7:0]   dir_c;
        logic [7:0]   wdt_pre;
        logic [7:0]   wdt_cnt;
        logic         wdt_en;
        logic         wdt_expire;
        logic         wake_s1;
        logic         wake_s2;
        sxe_fwr_type  fwr;
        logic         dp_write;
        logic [7:0]   dp_addr;
        logic [31:0]  hrdata;
        logic         hreadyout;
        logic         hresp;
    } sxe_state_type;

endpackage

// ==== sxe_core.sv ====
// Execution datapath: subtract, exclusive-OR, nibble swap, direction, sleep
`timescale 1ns/1ps
`include "sxe_cfg.svh"

module sxe_core
    import sxe_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Decoder side
    input  wire sxe_req_type req,
    input  wire logic        wake_pin,
    // Register file side
    output sxe_fwr_type      fwr,
    // Core state
    output logic [7:0]       acc,
    output logic             carry_flag,
    output logic             digit_carry_flag,
    output logic             zero_flag,
    output logic             powerdown_status_n,
    output logic             timeout_status_n,
    output logic [7:0]       port_a_direction,
    output logic [7:0]       port_b_direction,
    output logic [7:0]       port_c_direction,
    output logic             halt,
    output logic             osc_stop,
    output logic             wdt_expire,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    sxe_state_type s;
    sxe_state_type next_s;

    logic        exec;
    logic [8:0]  diff;
    logic [4:0]  ndiff;
    logic        cin;
    logic [7:0]  sub_a;
    logic [7:0]  result;
    logic        bus_addr_ph;
    logic [31:0] rd_word;
    logic        wdt_tick;
    logic        wdt_over;

    ////////////////////////////////////////////////////////////////////////
    // Datapath arithmetic

    // Instructions are ignored while the core sleeps
    assign exec  = req.valid && (s.mode == SXE_RUN);
    assign sub_a = (req.op == SXE_OP_LIT_SUB) ? req.operand : req.operand;
    // Borrow subtract feeds the stored carry in as the not-borrow
    assign cin   = (req.op == SXE_OP_FILE_SUBB) ? s.carry : 1'b1;
    // Adding the inverse plus one keeps carry as the not-borrow
    assign diff  = {1'b0, sub_a} + {1'b0, ~s.acc} + {8'h00, cin};
    assign ndiff = {1'b0, sub_a[3:0]} + {1'b0, ~s.acc[3:0]}
                 + {4'h0, cin};
    // Result mux per instruction
    always_comb begin
        unique case (req.op)
            SXE_OP_LIT_SUB, SXE_OP_FILE_SUB, SXE_OP_FILE_SUBB: begin
                result = diff[7:0];
            end
            SXE_OP_NIB_EX: begin
                result = {req.operand[3:0], req.operand[7:4]};
            end
            SXE_OP_XOR_LIT, SXE_OP_XOR_FILE: begin
                result = s.acc ^ req.operand;
            end
            default: begin
                result = `SXE_ZERO8;
            end
        endcase
    end

    // Watchdog prescaler wrap is the slow enable for the counter
    assign wdt_tick = s.wdt_en && (s.wdt_pre == 8'hff);
    // Count leaving the top is the time-out event
    assign wdt_over = wdt_tick && (s.wdt_cnt == 8'hff);

    ////////////////////////////////////////////////////////////////////////
    // Bus read mux

    assign bus_addr_ph = hsel && hready && htrans[1];
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (haddr[7:0])
            `SXE_ACC_OFS:    rd_word[7:0] = s.acc;
            `SXE_STATUS_OFS: begin
                rd_word[`SXE_ST_CARRY]  = s.carry;
                rd_word[`SXE_ST_DCARRY] = s.dcarry;
                rd_word[`SXE_ST_ZERO]   = s.zero;
                rd_word[`SXE_ST_PD_N]   = s.pd_n;
                rd_word[`SXE_ST_TO_N]   = s.to_n;
            end
            `SXE_DIR_A_OFS:  rd_word[7:0] = s.dir_a;
            `SXE_DIR_B_OFS:  rd_word[7:0] = s.dir_b;
            `SXE_DIR_C_OFS:  rd_word[7:0] = s.dir_c;
            `SXE_WDT_OFS:    rd_word[15:0] = {s.wdt_pre, s.wdt_cnt};
            `SXE_CTRL_OFS: begin
                rd_word[`SXE_CT_WDT_EN]   = s.wdt_en;
                rd_word[`SXE_CT_SLEEPING] = (s.mode == SXE_SLEEP);
            end
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s            = s;
        next_s.fwr.valid  = 1'b0;
        next_s.wdt_expire = 1'b0;
        next_s.hreadyout  = 1'b1;
        next_s.hresp      = 1'b0;
        // Wake pin passes two flops; only the second is read below
        next_s.wake_s1    = wake_pin;
        next_s.wake_s2    = s.wake_s1;

        // Watchdog runs in both modes so it can end a sleep
        if (s.wdt_en) begin
            next_s.wdt_pre = s.wdt_pre + 8'h01;
            if (wdt_tick) begin
                next_s.wdt_cnt = s.wdt_cnt + 8'h01;
                if (wdt_over) begin
                    next_s.wdt_expire = 1'b1;
                    next_s.to_n       = 1'b0;
                    next_s.mode       = SXE_RUN;
                end
            end
        end

        // Pin wake leaves sleep; status bits keep the sleep record
        if (s.mode == SXE_SLEEP && s.wake_s2) begin
            next_s.mode = SXE_RUN;
        end

        if (exec) begin
            unique case (req.op)
                SXE_OP_LIT_SUB, SXE_OP_FILE_SUB, SXE_OP_FILE_SUBB: begin
                    next_s.carry  = diff[8];
                    next_s.dcarry = ndiff[4];
                    next_s.zero   = (diff[7:0] == 8'h00);
                end
                SXE_OP_XOR_LIT, SXE_OP_XOR_FILE: begin
                    next_s.zero   = (result == 8'h00);
                end
                SXE_OP_DIR_LOAD: begin
                    // Other selects leave every direction register alone
                    if (req.addr == `SXE_DIR_SEL_A) begin
                        next_s.dir_a = s.acc;
                    end
                    if (req.addr == `SXE_DIR_SEL_B) begin
                        next_s.dir_b = s.acc;
                    end
                    if (req.addr == `SXE_DIR_SEL_C) begin
                        next_s.dir_c = s.acc;
                    end
                end
                SXE_OP_SLEEP: begin
                    next_s.pd_n    = 1'b0;
                    next_s.to_n    = 1'b1;
                    next_s.wdt_cnt = 8'h00;
                    next_s.wdt_pre = 8'h00;
                    next_s.mode    = SXE_SLEEP;
                end
                default: begin
                end
            endcase
            // Destination routing for results
            unique case (req.op)
                SXE_OP_LIT_SUB, SXE_OP_XOR_LIT: begin
                    next_s.acc = result;
                end
                SXE_OP_FILE_SUB, SXE_OP_FILE_SUBB, SXE_OP_NIB_EX,
                SXE_OP_XOR_FILE: begin
                    if (req.dest) begin
                        next_s.fwr.valid = 1'b1;
                        next_s.fwr.addr  = req.addr;
                        next_s.fwr.data  = result;
                    end else begin
                        next_s.acc = result;
                    end
                end
                default: begin
                end
            endcase
        end

        // A time-out that meets a sleep is still recorded: the event wins
        if (wdt_over) begin
            next_s.to_n = 1'b0;
        end

        // Bus data phase write; software wins over a same-cycle instruction
        if (s.dp_write) begin
            unique case (s.dp_addr)
                `SXE_ACC_OFS:    next_s.acc = hwdata[7:0];
                `SXE_STATUS_OFS: begin
                    next_s.carry  = hwdata[`SXE_ST_CARRY];
                    next_s.dcarry = hwdata[`SXE_ST_DCARRY];
                    next_s.zero   = hwdata[`SXE_ST_ZERO];
                end
                `SXE_DIR_A_OFS:  next_s.dir_a = hwdata[7:0];
                `SXE_DIR_B_OFS:  next_s.dir_b = hwdata[7:0];
                `SXE_DIR_C_OFS:  next_s.dir_c = hwdata[7:0];
                `SXE_CTRL_OFS: begin
                    next_s.wdt_en = hwdata[`SXE_CT_WDT_EN];
                    if (hwdata[`SXE_CT_WAKE]) begin
                        next_s.mode = SXE_RUN;
                    end
                end
                default: begin
                end
            endcase
        end

        // Address phase: latch write target, register read data now
        next_s.dp_write = bus_addr_ph && hwrite;
        next_s.dp_addr  = haddr[7:0];
        if (bus_addr_ph && !hwrite) begin
            next_s.hrdata = rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s           <= '0;
            s.mode      <= SXE_RUN;
            s.pd_n      <= 1'b1;
            s.to_n      <= 1'b1;
            s.dir_a     <= `SXE_DIR_RESET;
            s.dir_b     <= `SXE_DIR_RESET;
            s.dir_c     <= `SXE_DIR_RESET;
            s.hreadyout <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign fwr                = s.fwr;
    assign acc                = s.acc;
    assign carry_flag         = s.carry;
    assign digit_carry_flag   = s.dcarry;
    assign zero_flag          = s.zero;
    assign powerdown_status_n = s.pd_n;
    assign timeout_status_n   = s.to_n;
    assign port_a_direction   = s.dir_a;
    assign port_b_direction   = s.dir_b;
    assign port_c_direction   = s.dir_c;
    assign halt               = (s.mode == SXE_SLEEP);
    assign osc_stop           = (s.mode == SXE_SLEEP);
    assign wdt_expire         = s.wdt_expire;
    assign hrdata             = s.hrdata;
    assign hreadyout          = s.hreadyout;
    assign hresp              = s.hresp;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_lit_sub_acc: assert property (@(posedge clock) disable iff (rst)
        (exec && req.op == SXE_OP_LIT_SUB && !s.dp_write)
        |=> acc == 8'($past(req.operand) - $past(s.acc)))
        else $error("literal subtract result wrong");

    chk_sub_carry: assert property (@(posedge clock) disable iff (rst)
        (exec && req.op == SXE_OP_FILE_SUB && !s.dp_write)
        |=> carry_flag == ($past(s.acc) <= $past(req.operand)))
        else $error("subtract carry wrong");

    chk_sub_dcarry: assert property (@(posedge clock) disable iff (rst)
        (exec && req.op == SXE_OP_LIT_SUB && !s.dp_write)
        |=> digit_carry_flag ==
            ($past(s.acc[3:0]) <= $past(req.operand[3:0])))
        else $error("subtract digit carry wrong");

    chk_borrow_sub: assert property (@(posedge clock) disable iff (rst)
        (exec && req.op == SXE_OP_FILE_SUBB && req.dest)
        |=> fwr.valid && fwr.data == 8'($past(req.operand)
            - $past(s.acc) - {7'h00, !$past(s.carry)}))
        else $error("borrow subtract result wrong");

    chk_dest_file: assert property (@(posedge clock) disable iff (rst)
        (exec && req.op == SXE_OP_XOR_FILE && req.dest && !s.dp_write)
        |=> fwr.valid && acc == $past(s.acc)
            && fwr.addr == $past(req.addr))
        else $error("file destination not honoured");

    chk_swap_flags: assert property (@(posedge clock) disable iff (rst)
        (exec && req.op == SXE_OP_NIB_EX && !s.dp_write)
        |=> $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("swap changed flags");

    chk_xor_zero: assert property (@(posedge clock) disable iff (rst)
        (exec && req.op == SXE_OP_XOR_LIT && !s.dp_write)
        |=> zero_flag == (acc == 8'h00) && $stable(carry_flag))
        else $error("exclusive-OR zero flag wrong");

    chk_dir_load: assert property (@(posedge clock) disable iff (rst)
        (exec && req.op == SXE_OP_DIR_LOAD && req.addr == 7'h06
         && !s.dp_write)
        |=> port_b_direction == $past(s.acc))
        else $error("direction load missed");

    chk_sleep_entry: assert property (@(posedge clock) disable iff (rst)
        (exec && req.op == SXE_OP_SLEEP)
        |=> !powerdown_status_n && timeout_status_n == !$past(wdt_over)
            && halt && osc_stop && s.wdt_cnt == 8'h00)
        else $error("sleep entry wrong");

endmodule

// ==== sxe_regfile_model.sv ====
// Decoder and register file model that feeds the exec block
`timescale 1ns/1ps

module sxe_regfile_model
    import sxe_pkg::*;
(
    // Clock
    input  wire logic        clock,
    // Instruction fields from the bench
    input  wire logic        valid,
    input  wire sxe_op_type  op,
    input  wire logic [7:0]  literal,
    input  wire logic [6:0]  addr,
    input  wire logic        dest,
    // Write back from the exec block
    input  wire sxe_fwr_type fwr,
    // Instruction towards the exec block
    output sxe_req_type      req
);
    logic [7:0] mem [128];
    logic       lit_op;

    // Known but irregular contents so that nibble and flag cases vary
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 37 + 5);
        end
    end

    // Write back lands one edge after the pulse, as in the real file
    always @(posedge clock) begin
        if (fwr.valid) begin
            mem[fwr.addr] <= fwr.data;
        end
    end

    // Operand is the literal or the file contents; junk when not valid
    always_comb begin
        lit_op = (op == SXE_OP_LIT_SUB) || (op == SXE_OP_XOR_LIT);
        req.valid = valid;
        req.op = op;
        req.addr = addr;
        req.dest = dest;
        req.operand = lit_op ? literal : mem[addr];
        if (!valid) begin
            req.operand = ~mem[addr];
        end
    end
endmodule

// ==== cpu_subtract_xor_swap_exec_bench.sv ====
// Self-checking bench for the subtract, exclusive-OR and swap block
`timescale 1ns/1ps

module cpu_subtract_xor_swap_exec_bench;
    import sxe_pkg::*;

    logic        clock, rst, wake_pin, valid, dest, hsel, hwrite;
    logic [7:0]  lit, acc, dir_a, dir_b, dir_c;
    logic [6:0]  addr;
    sxe_op_type  op;
    sxe_req_type req;
    sxe_fwr_type fwr;
    logic        c_f, dc_f, z_f, pd_n, to_n, halt, osc_stop, wdt_exp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hready, hreadyout, hresp;
    int          error_cnt, n_compared;
    logic [7:0]  e_acc, e_fd;
    logic [7:0]  e_dir [3];
    logic        e_c, e_dc, e_z, e_pd, e_to, e_halt, e_fv;
    logic [6:0]  e_fa;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    sxe_core dut (.clock(clock), .rst(rst), .req(req), .wake_pin(wake_pin),
        .fwr(fwr), .acc(acc), .carry_flag(c_f), .digit_carry_flag(dc_f),
        .zero_flag(z_f), .powerdown_status_n(pd_n),
        .timeout_status_n(to_n), .port_a_direction(dir_a),
        .port_b_direction(dir_b), .port_c_direction(dir_c), .halt(halt),
        .osc_stop(osc_stop), .wdt_expire(wdt_exp), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp));

    sxe_regfile_model rf (.clock(clock), .valid(valid), .op(op),
        .literal(lit), .addr(addr), .dest(dest), .fwr(fwr), .req(req));

    ////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Outputs still show the previous instruction at this edge
    task automatic check_prev();
        chk("acc", e_acc, acc);
        chk("flags", {e_c, e_dc, e_z},
            {c_f, dc_f, z_f});
        chk("dirs", {e_dir[0], e_dir[1], e_dir[2]},
            {dir_a, dir_b, dir_c});
        chk("sleep", {e_halt, e_halt, e_pd, e_to},
            {halt, osc_stop, pd_n, to_n});
        chk("fwr_valid", e_fv, fwr.valid);
        if (e_fv) chk("fwr", {e_fa, e_fd}, {fwr.addr, fwr.data});
    endtask

    // Issue one instruction back to back and work out its effect
    task automatic exec(input sxe_op_type o, input logic [7:0] k,
                        input logic [6:0] a, input logic d);
        logic [7:0] v;
        logic [7:0] r;
        logic [8:0] s;
        logic [4:0] n;
        logic       b;
        logic       fo;
        v = (o == SXE_OP_LIT_SUB || o == SXE_OP_XOR_LIT) ? k : rf.mem[a];
        fo = o inside {SXE_OP_FILE_SUB, SXE_OP_FILE_SUBB, SXE_OP_NIB_EX,
                       SXE_OP_XOR_FILE};
        valid <= 1'b1;
        op <= o;
        lit <= k;
        addr <= a;
        dest <= d;
        @(posedge clock);
        check_prev();
        e_fv = 1'b0;
        if (!e_halt) begin
            b = (o == SXE_OP_FILE_SUBB) ? ~e_c : 1'b0;
            s = {1'b0, v} - {1'b0, e_acc} - {8'h00, b};
            n = {1'b0, v[3:0]} - {1'b0, e_acc[3:0]} - {4'h0, b};
            r = s[7:0];
            case (o)
                SXE_OP_LIT_SUB, SXE_OP_FILE_SUB, SXE_OP_FILE_SUBB: begin
                    e_c = ~s[8];
                    e_dc = ~n[4];
                    e_z = (r == 8'h00);
                end
                SXE_OP_NIB_EX: r = {v[3:0], v[7:4]};
                SXE_OP_XOR_LIT, SXE_OP_XOR_FILE: begin
                    r = v ^ e_acc;
                    e_z = (r == 8'h00);
                end
                SXE_OP_DIR_LOAD: if (a inside {[5:7]}) e_dir[a - 5] = e_acc;
                SXE_OP_SLEEP: begin
                    e_pd = 1'b0;
                    e_to = 1'b1;
                    e_halt = 1'b1;
                end
                default: ;
            endcase
            if (fo && d) begin
                e_fv = 1'b1;
                e_fa = a;
                e_fd = r;
            end else if (fo || o == SXE_OP_LIT_SUB || o == SXE_OP_XOR_LIT) begin
                e_acc = r;
            end
        end
    endtask

    // A do-nothing slot flushes the last check, then the port goes quiet
    task automatic idle();
        exec(SXE_OP_NONE, 8'h00, 7'h00, 1'b0);
        valid <= 1'b0;
    endtask

    // One single AHB-Lite transfer; read data taken at the data-phase edge
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int t;
        t = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do begin @(posedge clock); t++; end while (hready !== 1'b1 && t < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge clock); t++; end while (hready !== 1'b1 && t < 50);
        q = hrdata;
        if (t >= 50) error_cnt++;
        chk("hresp", 1'b0, hresp);
    endtask

    task automatic rd(input string nm, input logic [31:0] a,
                      input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        {valid, dest, wake_pin, hsel, hwrite} = 5'h00;
        op = SXE_OP_NONE;
        {lit, addr, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        {e_acc, e_c, e_dc, e_z, e_halt, e_fv, e_fa, e_fd} = '0;
        e_dir = '{8'hff, 8'hff, 8'hff};
        {e_pd, e_to} = 2'h3;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        exec(SXE_OP_XOR_LIT, 8'h21, 7'h00, 1'b0);
        exec(SXE_OP_LIT_SUB, 8'h13, 7'h00, 1'b0);
        exec(SXE_OP_XOR_LIT, 8'hf2, 7'h00, 1'b0);
        exec(SXE_OP_XOR_LIT, 8'h3c, 7'h00, 1'b0);
        exec(SXE_OP_LIT_SUB, 8'h3c, 7'h00, 1'b0);
        exec(SXE_OP_XOR_LIT, 8'h29, 7'h00, 1'b0);
        exec(SXE_OP_LIT_SUB, 8'h28, 7'h00, 1'b0);
        exec(SXE_OP_FILE_SUB, 8'h00, 7'h10, 1'b0);
        exec(SXE_OP_FILE_SUB, 8'h00, 7'h11, 1'b1);
        exec(SXE_OP_LIT_SUB, 8'hff, 7'h00, 1'b0);
        exec(SXE_OP_FILE_SUBB, 8'h00, 7'h12, 1'b1);
        exec(SXE_OP_LIT_SUB, 8'h00, 7'h00, 1'b0);
        exec(SXE_OP_FILE_SUBB, 8'h00, 7'h13, 1'b0);
        exec(SXE_OP_NIB_EX, 8'h00, 7'h14, 1'b0);
        exec(SXE_OP_NIB_EX, 8'h00, 7'h15, 1'b1);
        exec(SXE_OP_XOR_FILE, 8'h00, 7'h16, 1'b1);
        exec(SXE_OP_XOR_FILE, 8'h00, 7'h17, 1'b0);
        exec(SXE_OP_DIR_LOAD, 8'h00, 7'h05, 1'b0);
        exec(SXE_OP_XOR_LIT, 8'h0f, 7'h00, 1'b0);
        exec(SXE_OP_DIR_LOAD, 8'h00, 7'h06, 1'b0);
        exec(SXE_OP_XOR_LIT, 8'hf0, 7'h00, 1'b0);
        exec(SXE_OP_DIR_LOAD, 8'h00, 7'h07, 1'b0);
        exec(SXE_OP_DIR_LOAD, 8'h00, 7'h04, 1'b0);
        idle();
        rd("acc_reg", 32'h00, {24'h0, e_acc});
        rd("status_reg", 32'h04, {e_to, e_pd, e_z, e_dc, e_c});
        wr(32'h0c, 32'h5a);
        e_dir[1] = 8'h5a;
        rd("dir_b_reg", 32'h0c, 32'h5a);
        rd("unmapped", 32'h40, 32'h0);
        // Let the watchdog run out so that sleep has a time-out to undo
        wr(32'h18, 32'h1);
        for (int t = 0; t < 70000 && to_n !== 1'b0; t++) @(posedge clock);
        chk("wdt_expire", 1'b1, wdt_exp);
        chk("to_after_expire", 1'b0, to_n);
        e_to = 1'b0;
        // Leave some count behind, then freeze it so sleep must clear it
        repeat (300) @(posedge clock);
        wr(32'h18, 32'h0);
        exec(SXE_OP_SLEEP, 8'h00, 7'h00, 1'b0);
        exec(SXE_OP_XOR_LIT, 8'hff, 7'h00, 1'b0);
        idle();
        rd("wdt_reg", 32'h14, 32'h0);
        rd("ctrl_reg", 32'h18, 32'h4);
        wake_pin <= 1'b1;
        for (int t = 0; t < 8 && halt !== 1'b0; t++) @(posedge clock);
        chk("halt_after_wake", 1'b0, halt);
        wake_pin <= 1'b0;
        e_halt = 1'b0;
        exec(SXE_OP_XOR_LIT, 8'h55, 7'h00, 1'b0);
        // Second sleep, ended by the write-one wake bit this time
        exec(SXE_OP_SLEEP, 8'h00, 7'h00, 1'b0);
        idle();
        wr(32'h18, 32'h2);
        @(posedge clock);
        chk("halt_after_bus_wake", 1'b0, halt);
        e_halt = 1'b0;
        exec(SXE_OP_XOR_LIT, 8'h0a, 7'h00, 1'b0);
        idle();
        wrap_up();
    end

    // Hang guard: the watchdog run-out alone takes some 66 thousand cycles
    initial begin
        #400000;
        error_cnt++;
        wrap_up();
    end
endmodule
